// >>> lcs_pkg.sv
// package for the ten-cell logic cluster with add/subtract path
// Notes on behaviour
// - A cluster holds exactly ten cells joined by carry, table and register chains.
// - Each cell but the last passes its table output straight to the next cell's table input; the last one's reaches lutChainOut a cycle late.
// - Each cell's stored value can be loaded into the next cell's register.
// - Registers can shift along the chain while the tables compute something unrelated.
// - A packing option feeds a cell's own register output back into its table.
// - Each cell gives only registered results on three routing outputs, with table and result captured one cycle late, plus three chains.
// - One cluster-wide select makes every arithmetic cell add A plus B or subtract B from A.
// - Subtraction inverts every B bit and forces the carry into the chain to one.
// - Each cell runs in normal mode or dynamic arithmetic mode.
// - Each cell takes eight inputs: four data, two carries, the cluster carry and the register chain.
// - Every cell register shares the cluster clock and cluster asynchronous clear.
package lcs_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int LCS_CELLS = 10;
    localparam int LCS_DATA_INS = 4;
    localparam int LCS_ROUTE_OUTS = 3;
    localparam int LCS_LUT_BITS = 16;
    localparam int LCS_IDX_W = 4;

    // ************************************************************
    // routing output positions
    // ************************************************************
    localparam int LCS_ROUTE_COMB = 0;
    localparam int LCS_ROUTE_REG = 1;
    localparam int LCS_ROUTE_RESULT = 2;

    // ************************************************************
    // data input positions
    // ************************************************************
    localparam int LCS_IN_A = 0;
    localparam int LCS_IN_B = 1;
    localparam int LCS_IN_DIRECT = 2;
    localparam int LCS_IN_FEEDBACK = 3;

    // ************************************************************
    // carry start values and reset values
    // ************************************************************
    localparam logic LCS_CARRY_A_START = 1'b0;
    localparam logic LCS_CARRY_B_START = 1'b1;
    localparam logic LCS_REG_RST = 1'b0;
    localparam logic [LCS_LUT_BITS-1:0] LCS_MASK_RST = 16'h0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic {LCS_NORMAL, LCS_ARITH} lcs_mode_t;
    typedef enum logic [1:0] {LCS_REG_RESULT, LCS_REG_CHAIN, LCS_REG_DIRECT} lcs_regsrc_t;

    typedef struct packed {
        lcs_mode_t mode;
        lcs_regsrc_t regSrc;
        logic lutFeedback;
        logic lutChainUse;
        logic [LCS_LUT_BITS-1:0] lutMask;
    } lcs_cell_cfg_t;

    typedef struct packed {
        logic [LCS_DATA_INS-1:0] data;
        logic carryPathAIn;
        logic carryPathBIn;
        logic clusterCarryIn;
        logic regChainIn;
        logic lutChainIn;
        logic invertB;
    } lcs_cell_in_t;

    typedef struct packed {
        logic lutComb;
        logic regQ;
        logic result;
        logic carryPathAOut;
        logic carryPathBOut;
    } lcs_cell_out_t;

    localparam lcs_cell_cfg_t LCS_CFG_RST = '{LCS_NORMAL, LCS_REG_RESULT, 1'b0, 1'b0, LCS_MASK_RST};

    // ************************************************************
    // full adder helpers
    // ************************************************************
    function automatic logic lcs_sum(input logic a, input logic b, input logic c);
        lcs_sum = a ^ b ^ c;
    endfunction

    function automatic logic lcs_carry(input logic a, input logic b, input logic c);
        lcs_carry = (a & b) | (a & c) | (b & c);
    endfunction

endpackage

// >>> lcs_cell.sv
// one logic cell: table, register, dual carry path
`timescale 1ns/1ps
module lcs_cell (
    // clock and cluster controls
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic clusterClr,
    // configuration
    input wire lcs_pkg::lcs_cell_cfg_t cfg,
    // eight inputs plus chain and select
    input wire lcs_pkg::lcs_cell_in_t cin,
    // results
    output lcs_pkg::lcs_cell_out_t cout
);

    // ************************************************************
    // table and arithmetic
    // ************************************************************
    logic regQ_q;
    logic regQ_d;
    logic [lcs_pkg::LCS_DATA_INS-1:0] lutIdx;
    logic lutComb;
    logic opA;
    logic opB;
    logic sumA;
    logic sumB;

    always_comb begin
        lutIdx = cin.data;
        if (cfg.lutChainUse) begin
            lutIdx[lcs_pkg::LCS_IN_A] = cin.lutChainIn;
        end
        if (cfg.lutFeedback) begin
            lutIdx[lcs_pkg::LCS_IN_FEEDBACK] = regQ_q;
        end
        lutComb = cfg.lutMask[lutIdx];
        opA = cin.data[lcs_pkg::LCS_IN_A];
        opB = cin.data[lcs_pkg::LCS_IN_B] ^ cin.invertB;
        sumA = lcs_pkg::lcs_sum(opA, opB, cin.carryPathAIn);
        sumB = lcs_pkg::lcs_sum(opA, opB, cin.carryPathBIn);
        cout.lutComb = lutComb;
        cout.regQ = regQ_q;
        if (cfg.mode == lcs_pkg::LCS_ARITH) begin
            cout.result = cin.clusterCarryIn ? sumB : sumA;
            cout.carryPathAOut = lcs_pkg::lcs_carry(opA, opB, cin.carryPathAIn);
            cout.carryPathBOut = lcs_pkg::lcs_carry(opA, opB, cin.carryPathBIn);
        end else begin
            cout.result = lutComb;
            cout.carryPathAOut = cin.carryPathAIn;
            cout.carryPathBOut = cin.carryPathBIn;
        end
    end

    // ************************************************************
    // register
    // ************************************************************
    always_comb begin
        case (cfg.regSrc)
            lcs_pkg::LCS_REG_RESULT: regQ_d = cout.result;
            lcs_pkg::LCS_REG_CHAIN: regQ_d = cin.regChainIn;
            lcs_pkg::LCS_REG_DIRECT: regQ_d = cin.data[lcs_pkg::LCS_IN_DIRECT];
            default: regQ_d = lcs_pkg::LCS_REG_RST;
        endcase
    end

    always_ff @(posedge core_clk or posedge clusterClr) begin
        if (clusterClr) begin
            regQ_q <= lcs_pkg::LCS_REG_RST;
        end else if (!rstn) begin
            regQ_q <= lcs_pkg::LCS_REG_RST;
        end else begin
            regQ_q <= regQ_d;
        end
    end

endmodule // lcs_cell

// >>> lcs_cluster.sv
// ten-cell logic cluster with chains and add/subtract select
`timescale 1ns/1ps
module lcs_cluster (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // cluster-wide controls
    input wire logic clusterClr,
    input wire logic addNotSub,
    // configuration load
    input wire logic cfgWrite,
    input wire logic [lcs_pkg::LCS_IDX_W-1:0] cfgIndex,
    input wire lcs_pkg::lcs_cell_cfg_t cfgData,
    // local routing data, four per cell
    input wire logic [lcs_pkg::LCS_CELLS-1:0][lcs_pkg::LCS_DATA_INS-1:0] cellData,
    // links from the previous cluster
    input wire logic clusterCarryIn,
    input wire logic regChainIn,
    // general routing outputs, three per cell
    output logic [lcs_pkg::LCS_CELLS-1:0][lcs_pkg::LCS_ROUTE_OUTS-1:0] routeOut,
    // links to the next cluster
    output logic clusterCarryOut,
    output logic regChainOut,
    output logic lutChainOut,
    // configuration readback of the selected cell
    output lcs_pkg::lcs_cell_cfg_t cfgReadback
);

    // ************************************************************
    // configuration store
    // ************************************************************
    lcs_pkg::lcs_cell_cfg_t cfgMem_q [lcs_pkg::LCS_CELLS];
    lcs_pkg::lcs_cell_cfg_t cfgMem_d [lcs_pkg::LCS_CELLS];
    lcs_pkg::lcs_cell_cfg_t cfgReadback_q;
    lcs_pkg::lcs_cell_cfg_t cfgReadback_d;
    logic cfgHit;

    always_comb begin
        cfgHit = (cfgIndex < lcs_pkg::LCS_IDX_W'(lcs_pkg::LCS_CELLS));
        for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
            cfgMem_d[i] = cfgMem_q[i];
            if (cfgWrite && cfgHit && (cfgIndex == lcs_pkg::LCS_IDX_W'(i))) begin
                cfgMem_d[i] = cfgData;
            end
        end
        cfgReadback_d = lcs_pkg::LCS_CFG_RST;
        if (cfgHit) begin
            cfgReadback_d = cfgMem_q[cfgIndex];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
                cfgMem_q[i] <= lcs_pkg::LCS_CFG_RST;
            end
            cfgReadback_q <= lcs_pkg::LCS_CFG_RST;
        end else begin
            for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
                cfgMem_q[i] <= cfgMem_d[i];
            end
            cfgReadback_q <= cfgReadback_d;
        end
    end

    assign cfgReadback = cfgReadback_q;

    // ************************************************************
    // cluster-wide add/subtract control
    // ************************************************************
    logic subSel;
    logic carrySel;

    always_comb begin
        subSel = ~addNotSub;
        carrySel = clusterCarryIn | subSel;
    end

    // ************************************************************
    // cell inputs and chain wiring
    // ************************************************************
    lcs_pkg::lcs_cell_in_t cellIn [lcs_pkg::LCS_CELLS];
    lcs_pkg::lcs_cell_out_t cellOut [lcs_pkg::LCS_CELLS];

    always_comb begin
        for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
            cellIn[i].data = cellData[i];
            cellIn[i].clusterCarryIn = carrySel;
            cellIn[i].invertB = subSel;
            if (i == 0) begin
                cellIn[i].carryPathAIn = lcs_pkg::LCS_CARRY_A_START;
                cellIn[i].carryPathBIn = lcs_pkg::LCS_CARRY_B_START;
                cellIn[i].regChainIn = regChainIn;
                cellIn[i].lutChainIn = 1'b0;
            end else begin
                cellIn[i].carryPathAIn = cellOut[i-1].carryPathAOut;
                cellIn[i].carryPathBIn = cellOut[i-1].carryPathBOut;
                cellIn[i].regChainIn = cellOut[i-1].regQ;
                cellIn[i].lutChainIn = cellOut[i-1].lutComb;
            end
        end
    end

    // ************************************************************
    // the ten cells
    // ************************************************************
    for (genvar g = 0; g < lcs_pkg::LCS_CELLS; g++) begin : gCell
        lcs_cell uCell (
            .core_clk(core_clk),
            .rstn(rstn),
            .clusterClr(clusterClr),
            .cfg(cfgMem_q[g]),
            .cin(cellIn[g]),
            .cout(cellOut[g])
        );
    end

    // ************************************************************
    // output capture
    // ************************************************************
    logic [lcs_pkg::LCS_CELLS-1:0] combOut_q;
    logic [lcs_pkg::LCS_CELLS-1:0] combOut_d;
    logic [lcs_pkg::LCS_CELLS-1:0] resultOut_q;
    logic [lcs_pkg::LCS_CELLS-1:0] resultOut_d;
    logic [lcs_pkg::LCS_CELLS-1:0] regOut;
    logic carryOut_q;
    logic carryOut_d;
    lcs_pkg::lcs_cell_out_t lastCell;

    always_comb begin
        for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
            combOut_d[i] = cellOut[i].lutComb;
            resultOut_d[i] = cellOut[i].result;
            regOut[i] = cellOut[i].regQ;
        end
        lastCell = cellOut[lcs_pkg::LCS_CELLS-1];
        carryOut_d = carrySel ? lastCell.carryPathBOut : lastCell.carryPathAOut;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            combOut_q <= '0;
            resultOut_q <= '0;
            carryOut_q <= 1'b0;
        end else begin
            combOut_q <= combOut_d;
            resultOut_q <= resultOut_d;
            carryOut_q <= carryOut_d;
        end
    end

    // ************************************************************
    // routing outputs
    // ************************************************************
    always_comb begin
        for (int i = 0; i < lcs_pkg::LCS_CELLS; i++) begin
            routeOut[i][lcs_pkg::LCS_ROUTE_COMB] = combOut_q[i];
            routeOut[i][lcs_pkg::LCS_ROUTE_REG] = regOut[i];
            routeOut[i][lcs_pkg::LCS_ROUTE_RESULT] = resultOut_q[i];
        end
        clusterCarryOut = carryOut_q;
        regChainOut = regOut[lcs_pkg::LCS_CELLS-1];
        lutChainOut = combOut_q[lcs_pkg::LCS_CELLS-1];
    end

endmodule // lcs_cluster

// >>> lcs_cluster_props.sv
// checker for the ten-cell logic cluster ports
`timescale 1ns/1ps
module lcs_cluster_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // controls and data
    input wire logic clusterClr,
    input wire logic addNotSub,
    input wire logic cfgWrite,
    input wire logic [lcs_pkg::LCS_IDX_W-1:0] cfgIndex,
    input wire lcs_pkg::lcs_cell_cfg_t cfgData,
    input wire logic [lcs_pkg::LCS_CELLS-1:0][lcs_pkg::LCS_DATA_INS-1:0] cellData,
    input wire logic clusterCarryIn,
    input wire logic regChainIn,
    // outputs
    input wire logic [lcs_pkg::LCS_CELLS-1:0][lcs_pkg::LCS_ROUTE_OUTS-1:0] routeOut,
    input wire logic clusterCarryOut,
    input wire logic regChainOut,
    input wire logic lutChainOut,
    input wire lcs_pkg::lcs_cell_cfg_t cfgReadback
);
    logic [9:0] arith_q;
    logic [9:0] chain_q;
    logic [9:0] aVec;
    logic [9:0] bVec;
    logic [9:0] resBits;
    logic [10:0] sumExp;
    logic carryExp;
    // shadow of written cell modes
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            arith_q <= '0;
            chain_q <= '0;
        end else if (cfgWrite && cfgIndex < 4'ha) begin
            arith_q[cfgIndex] <= (cfgData.mode == lcs_pkg::LCS_ARITH);
            chain_q[cfgIndex] <= (cfgData.regSrc == lcs_pkg::LCS_REG_CHAIN);
        end
    end
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            aVec[i] = cellData[i][0];
            bVec[i] = cellData[i][1] ^ ~addNotSub;
            resBits[i] = routeOut[i][2];
        end
        sumExp = {1'b0, aVec} + {1'b0, bVec} + {10'h000, clusterCarryIn | ~addNotSub};
        carryExp = sumExp[10];
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_cfgHeld;
        cfgWrite && cfgIndex < 4'ha ##1 !cfgWrite && $stable(cfgIndex);
    endsequence
    sequence s_allArith;
        (&arith_q) && !cfgWrite;
    endsequence
    AST_CFG_READBACK: assert property (s_cfgHeld |=> cfgReadback == $past(cfgData, 2))
        else $error("config readback differs from written value");
    AST_SUM_BITS: assert property (s_allArith |=> {1'b0, resBits} == ($past(sumExp) & 11'h3ff))
        else $error("arithmetic result bits wrong");
    AST_CARRY_OUT: assert property (s_allArith |=> clusterCarryOut == $past(carryExp))
        else $error("cluster carry out wrong");
    AST_SUB_EQUAL: assert property (s_allArith ##0
        (!addNotSub && !clusterCarryIn && bVec == ~aVec)
        |=> resBits == 10'h000 && clusterCarryOut)
        else $error("equal operands do not subtract to zero");
    AST_CHAIN_CELL1: assert property (chain_q[1] && !cfgWrite && !clusterClr
        ##1 !clusterClr |-> routeOut[1][1] == $past(routeOut[0][1]))
        else $error("register chain did not shift into cell 1");
    AST_CHAIN_ENTRY: assert property (chain_q[0] && !cfgWrite && !clusterClr
        ##1 !clusterClr |-> routeOut[0][1] == $past(regChainIn))
        else $error("register chain input not loaded into cell 0");
    AST_ASYNC_CLEAR: assert property (clusterClr |-> !regChainOut && !routeOut[0][1])
        else $error("cell registers not cleared");
    AST_RESET_ZERO: assert property ($rose(rstn) |-> routeOut == '0 && !lutChainOut)
        else $error("outputs not zero after reset");
    AST_CHAIN_ENDS: assert property (chain_q[9] && !cfgWrite && !clusterClr
        ##1 !clusterClr |-> regChainOut == $past(routeOut[8][1]))
        else $error("register chain did not shift into the last cell");
endmodule // lcs_cluster_props

bind lcs_cluster lcs_cluster_props u_lcs_cluster_props (.core_clk(core_clk), .rstn(rstn),
    .clusterClr(clusterClr), .addNotSub(addNotSub), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex),
    .cfgData(cfgData), .cellData(cellData), .clusterCarryIn(clusterCarryIn),
    .regChainIn(regChainIn), .routeOut(routeOut), .clusterCarryOut(clusterCarryOut),
    .regChainOut(regChainOut), .lutChainOut(lutChainOut), .cfgReadback(cfgReadback));

// >>> lcs_prev_cluster.sv
// model of the preceding cluster feeding carry and register chain
`timescale 1ns/1ps
module lcs_prev_cluster (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // bench controls
    input wire logic shiftIn,
    input wire logic carrySet,
    // links into the cluster
    output logic regChainIn,
    output logic clusterCarryIn
);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            regChainIn <= 1'b0;
            clusterCarryIn <= 1'b0;
        end else begin
            regChainIn <= shiftIn;
            clusterCarryIn <= carrySet;
        end
    end
endmodule // lcs_prev_cluster

// >>> lcs_cluster_tb_top.sv
// testbench for the ten-cell logic cluster
`timescale 1ns/1ps
module lcs_cluster_tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic clusterClr = 1'b0;
    logic addNotSub = 1'b1;
    logic cfgWrite = 1'b0;
    logic [3:0] cfgIndex = 4'h0;
    lcs_pkg::lcs_cell_cfg_t cfgData = lcs_pkg::LCS_CFG_RST;
    logic [9:0][3:0] cellData = '0;
    logic shiftIn = 1'b0;
    logic carrySet = 1'b0;
    logic clusterCarryIn, regChainIn, clusterCarryOut, regChainOut, lutChainOut;
    logic [9:0][2:0] routeOut;
    lcs_pkg::lcs_cell_cfg_t cfgReadback;
    int errorCnt = 0;
    int testsRun = 0;
    lcs_cluster u_lcs_cluster (.core_clk(core_clk), .rstn(rstn), .clusterClr(clusterClr),
        .addNotSub(addNotSub), .cfgWrite(cfgWrite), .cfgIndex(cfgIndex), .cfgData(cfgData),
        .cellData(cellData), .clusterCarryIn(clusterCarryIn), .regChainIn(regChainIn),
        .routeOut(routeOut), .clusterCarryOut(clusterCarryOut), .regChainOut(regChainOut),
        .lutChainOut(lutChainOut), .cfgReadback(cfgReadback));
    lcs_prev_cluster u_lcs_prev_cluster (.core_clk(core_clk), .rstn(rstn), .shiftIn(shiftIn),
        .carrySet(carrySet), .regChainIn(regChainIn), .clusterCarryIn(clusterCarryIn));
    initial forever #5 core_clk = ~core_clk;
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (errorCnt == 0 && testsRun > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask
    task automatic cfgSet(input logic [3:0] first, input logic [3:0] last,
        input lcs_pkg::lcs_cell_cfg_t c);
        cfgWrite = 1'b1;
        cfgData = c;
        for (logic [4:0] i = {1'b0, first}; i <= {1'b0, last}; i++) begin
            cfgIndex = i[3:0];
            tick();
        end
        cfgWrite = 1'b0;
    endtask
    task automatic readbackTest();
        lcs_pkg::lcs_cell_cfg_t c;
        c = '{lcs_pkg::LCS_ARITH, lcs_pkg::LCS_REG_DIRECT, 1'b1, 1'b0, 16'h5a3c};
        cfgSet(4'h3, 4'h3, c);
        tick();
        check("readback cell 3", cfgReadback, c);
        cfgSet(4'hc, 4'hc, c);
        check("readback index 12", cfgReadback, lcs_pkg::LCS_CFG_RST);
        cfgIndex = 4'h3;
        cellData[3] = 4'h4;
        tick();
        check("readback after refused write", cfgReadback, c);
        check("direct register load", 20'(routeOut[3][1]), 20'h00001);
    endtask
    task automatic addSubTest();
        logic [9:0] a [4] = '{10'h3ff, 10'h155, 10'h200, 10'h0a5};
        logic [9:0] b [4] = '{10'h001, 10'h155, 10'h3ff, 10'h05a};
        logic [10:0] exp;
        logic [9:0] res;
        logic sub;
        cfgSet(4'h0, 4'h9, '{lcs_pkg::LCS_ARITH, lcs_pkg::LCS_REG_RESULT, 1'b0, 1'b0, 16'h0000});
        for (int k = 0; k < 8; k++) begin
            sub = k[0];
            addNotSub = ~sub;
            carrySet = k[2];
            for (int i = 0; i < 10; i++) cellData[i] = {2'b00, b[k/2][i], a[k/2][i]};
            tick();
            tick();
            exp = {1'b0, a[k/2]} + {1'b0, sub ? ~b[k/2] : b[k/2]} + {10'h000, k[2] | sub};
            for (int i = 0; i < 10; i++) res[i] = routeOut[i][2];
            check("sum and carry", {9'h000, clusterCarryOut, res}, {9'h000, exp});
            check("sum held in cell 0", 20'(routeOut[0][1]), 20'(exp[0]));
        end
    endtask
    task automatic shiftClearTest();
        logic [9:0] pat = 10'h2b5;
        cfgSet(4'h0, 4'h9, '{lcs_pkg::LCS_NORMAL, lcs_pkg::LCS_REG_CHAIN, 1'b0, 1'b0, 16'h8000});
        cellData = {10{4'hf}};
        for (int j = 0; j < 11; j++) begin
            shiftIn = (j < 10) ? pat[j] : 1'b0;
            tick();
        end
        check("chain output", 20'(regChainOut), 20'(pat[0]));
        for (int i = 0; i < 10; i++) check("chain cell", 20'(routeOut[i][1]), 20'(pat[9-i]));
        check("table beside shift", 20'(routeOut[0][0]), 20'h00001);
        check("table chain output", 20'(lutChainOut), 20'h00001);
        clusterClr = 1'b1;
        #2;
        for (int i = 0; i < 10; i++) check("cleared cell", 20'(routeOut[i][1]), 20'h00000);
        tick();
        clusterClr = 1'b0;
    endtask
    task automatic lutTest();
        cfgSet(4'h0, 4'h9, '{lcs_pkg::LCS_NORMAL, lcs_pkg::LCS_REG_RESULT, 1'b0, 1'b1, 16'h5555});
        tick();
        for (int i = 0; i < 10; i++) begin
            check("table chain cell", 20'(routeOut[i][0]), 20'(1 - i % 2));
        end
        check("table chain end", 20'(lutChainOut), 20'h00000);
        cfgSet(4'h0, 4'h0, '{lcs_pkg::LCS_NORMAL, lcs_pkg::LCS_REG_RESULT, 1'b1, 1'b0, 16'h00ff});
        tick();
        check("feedback toggle low", 20'(routeOut[0][1]), 20'h00000);
        tick();
        check("feedback toggle high", 20'(routeOut[0][1]), 20'h00001);
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        readbackTest();
        addSubTest();
        shiftClearTest();
        lutTest();
        conclude();
    end
    initial begin
        #20000;
        errorCnt++;
        conclude();
    end
endmodule // lcs_cluster_tb_top
